// ==== src/vta_pkg.sv ====
// Purpose: Constants and types shared by the VLAN table staging registers
// Assumes: Byte-wide register port, big-endian byte order within a word
// Notes:   Table entry packs every staged field into one word
package vta_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          IDX_W         = 12;
  localparam int          PORTS         = 7;
  localparam int          ENTRY_W       = 29;
  localparam logic [12:0] TABLE_DEPTH   = 13'h1000;
  // Byte addresses of the register window
  localparam logic [15:0] OFS_WORD0     = 16'h0400;
  localparam logic [15:0] OFS_UNTAG     = 16'h0404;
  localparam logic [15:0] OFS_FWD       = 16'h0408;
  localparam logic [15:0] OFS_SELECT    = 16'h040C;
  localparam logic [15:0] OFS_CTRL      = 16'h040E;
  // Field positions in the first entry word
  localparam int          POS_VALID     = 31;
  localparam int          POS_FORWARD_OPTION_BIT   = 27;
  localparam int          POS_PRIO_LO   = 24;
  localparam int          POS_MSTP_LO   = 12;
  localparam int          POS_FILTER_IDENTIFIER_LO = 0;
  // Field positions in the control byte
  localparam int          POS_START     = 7;
  localparam int          POS_ACT_LO    = 0;
  // Field positions in a packed table entry
  localparam int          ENT_VALID     = 28;
  localparam int          ENT_FORWARD_OPTION_BIT   = 27;
  localparam int          ENT_PRIO_LO   = 24;
  localparam int          ENT_MSTP_LO   = 21;
  localparam int          ENT_FILTER_IDENTIFIER_LO = 14;
  localparam int          ENT_UNTAG_LO  = 7;
  localparam int          ENT_FWD_LO    = 0;
  // Reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [11:0] RST_INDEX     = 12'h000;

  typedef enum logic [1:0] {
    VTA_ACT_NOP   = 2'b00,
    VTA_ACT_WRITE = 2'b01,
    VTA_ACT_READ  = 2'b10,
    VTA_ACT_CLEAR = 2'b11
  } vta_action_t;

  typedef enum logic [1:0] {
    VTA_SRC_ALU     = 2'b00,
    VTA_SRC_PORTMAP = 2'b01,
    VTA_SRC_BOTH    = 2'b10,
    VTA_SRC_UNKNOWN = 2'b11
  } vta_fwd_src_t;

  typedef enum logic [1:0] {
    VTA_ST_IDLE   = 2'b00,
    VTA_ST_ACCESS = 2'b01,
    VTA_ST_CLEAR  = 2'b10
  } vta_state_t;
endpackage : vta_pkg

// ==== src/vta_regs.sv ====
// Purpose: Staging registers and sequencer for one VLAN table entry access
// Assumes: Table memory answers each request with a one-cycle ack
// Notes:   Also decodes a looked-up entry into forwarding and untag maps
// What this block does
// - An entry counts as valid only when its valid bit is 1.
// - With the forward option set, frames go to the entry's own forward map.
// - With the forward option clear, ports come from lookup map, port map, both, or unknown handling.
// - Priority is three bits at 26:24 of the first entry word.
// - Spanning tree instance index is three bits at 14:12 of the first entry word.
// - A seven-bit filter identifier is kept per entry and passed on for address hashing.
// - Ports set in the untag map strip the tag on egress, others keep it.
// - Map bits 0 to 6 stand for switch ports 1 to 7.
// - The forward map is applied only when the forward option is set.
// - A 12-bit index in bits 11:0 of the select register picks the entry for the next action.
// - Writing 1 to start launches an action and hardware clears it when done.
// - Action 00 does nothing, 01 writes, 10 reads, 11 clears every entry.
`timescale 1ns/10ps
module vta_regs
  import vta_pkg::*;
#(
  parameter int PORTS_P = vta_pkg::PORTS
)(
  input  wire logic                          i_clock,      // 125 MHz core clock
  input  wire logic                          i_nrst,       // Async reset, active low
  input  wire logic [vta_pkg::ADDR_W-1:0]    i_reg_addr,   // Register byte address
  input  wire logic                          i_reg_wr,     // Byte write strobe
  input  wire logic [7:0]                    i_reg_wdata,  // Byte write data
  input  wire logic                          i_reg_rd,     // Byte read strobe
  output logic      [7:0]                    o_reg_rdata,  // Byte read data
  output logic                               o_tbl_req,    // Table access request
  output logic                               o_tbl_we,     // Table write enable
  output logic      [vta_pkg::IDX_W-1:0]     o_tbl_addr,   // Table entry address
  output logic      [vta_pkg::ENTRY_W-1:0]   o_tbl_wdata,  // Table write data
  input  wire logic [vta_pkg::ENTRY_W-1:0]   i_tbl_rdata,  // Table read data
  input  wire logic                          i_tbl_ack,    // Table access done
  output logic                               o_busy,       // Action in progress
  input  wire logic                          i_lkp_valid,  // Looked-up entry present
  input  wire logic [vta_pkg::ENTRY_W-1:0]   i_lkp_entry,  // Looked-up entry
  input  wire logic [1:0]                    i_fwd_src,    // Fallback port source
  input  wire logic [PORTS_P-1:0]            i_alu_map,    // Address lookup ports
  input  wire logic [PORTS_P-1:0]            i_vlan_map,   // Port VLAN membership
  input  wire logic [PORTS_P-1:0]            i_unknown_map, // Unknown unicast/multicast ports
  output logic                               o_lkp_hit,    // Entry was valid
  output logic      [PORTS_P-1:0]            o_fwd_ports,  // Forward ports, bit0 is port 1
  output logic      [PORTS_P-1:0]            o_untag_ports, // Untag ports, bit0 is port 1
  output logic      [2:0]                    o_lkp_prio,   // Entry priority
  output logic      [2:0]                    o_lkp_mstp,   // Entry spanning tree index
  output logic      [6:0]                    o_lkp_filter_identifier // Filter identifier for hashing
);
  import vta_pkg::*;

  logic                 rst_meta_reg;
  logic                 rst_sync_reg;
  logic                 valid_reg;
  logic                 forward_option_bit_reg;
  logic [2:0]           prio_reg;
  logic [2:0]           mstp_reg;
  logic [6:0]           filter_identifier_reg;
  logic [PORTS_P-1:0]   untag_reg;
  logic [PORTS_P-1:0]   fwd_reg;
  logic [IDX_W-1:0]     index_reg;
  logic                 start_reg;
  vta_action_t          action_reg;
  vta_state_t           state_reg;
  vta_state_t           state_next;
  logic [IDX_W-1:0]     clr_cnt_reg;
  logic [31:0]          word0;
  logic [31:0]          word_untag;
  logic [31:0]          word_fwd;
  logic [15:0]          word_sel;
  logic                 ctrl_wr;
  logic                 stage_wr;
  logic                 rd_ack;
  logic [ENTRY_W-1:0]   staged_entry;
  logic [7:0]           rd_byte;
  logic                 lkp_forward_option_bit;
  logic [PORTS_P-1:0]   fallback_map;

  // Reset release through two flops
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Ignored once start is set, so an action cannot lose its start bit
  assign ctrl_wr  = i_reg_wr && (i_reg_addr == OFS_CTRL) && (state_reg == VTA_ST_IDLE) && !start_reg;
  // Staging frozen while an action runs
  assign stage_wr = i_reg_wr && (state_reg == VTA_ST_IDLE) && !start_reg;
  assign rd_ack   = (state_reg == VTA_ST_ACCESS) && i_tbl_ack && !o_tbl_we;

  // Word views, reserved bits zero
  assign word0      = {valid_reg, 3'b000, forward_option_bit_reg, prio_reg, 9'h000,
                       mstp_reg, 5'h00, filter_identifier_reg};
  assign word_untag = {{(32-PORTS_P){1'b0}}, untag_reg};
  assign word_fwd   = {{(32-PORTS_P){1'b0}}, fwd_reg};
  assign word_sel   = {4'h0, index_reg};

  assign staged_entry = {valid_reg, forward_option_bit_reg, prio_reg, mstp_reg,
                         filter_identifier_reg, untag_reg, fwd_reg};

  // Staging fields: byte writes, or loaded by a read action
  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      valid_reg             <= 1'b0;
      forward_option_bit_reg <= 1'b0;
      prio_reg              <= 3'h0;
      mstp_reg              <= 3'h0;
      filter_identifier_reg <= 7'h00;
      untag_reg             <= '0;
      fwd_reg               <= '0;
    end
    else if (rd_ack)
    begin
      valid_reg             <= i_tbl_rdata[ENT_VALID];
      forward_option_bit_reg <= i_tbl_rdata[ENT_FORWARD_OPTION_BIT];
      prio_reg              <= i_tbl_rdata[ENT_PRIO_LO +: 3];
      mstp_reg              <= i_tbl_rdata[ENT_MSTP_LO +: 3];
      filter_identifier_reg <= i_tbl_rdata[ENT_FILTER_IDENTIFIER_LO +: 7];
      untag_reg             <= i_tbl_rdata[ENT_UNTAG_LO +: PORTS_P];
      fwd_reg               <= i_tbl_rdata[ENT_FWD_LO +: PORTS_P];
    end
    else if (stage_wr)
    begin
      case (i_reg_addr)
        OFS_WORD0:
        begin
          valid_reg <= i_reg_wdata[POS_VALID-24];
          forward_option_bit_reg <= i_reg_wdata[POS_FORWARD_OPTION_BIT-24];
          prio_reg  <= i_reg_wdata[POS_PRIO_LO-24 +: 3];
        end
        OFS_WORD0 + 16'h0002: mstp_reg <= i_reg_wdata[POS_MSTP_LO-8 +: 3];
        OFS_WORD0 + 16'h0003: filter_identifier_reg <= i_reg_wdata[POS_FILTER_IDENTIFIER_LO +: 7];
        OFS_UNTAG + 16'h0003: untag_reg <= i_reg_wdata[PORTS_P-1:0];
        OFS_FWD + 16'h0003:   fwd_reg   <= i_reg_wdata[PORTS_P-1:0];
        default:              ;
      endcase
    end
  end

  // Entry index
  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      index_reg <= RST_INDEX;
    else if (stage_wr && i_reg_addr == OFS_SELECT)
      index_reg[11:8] <= i_reg_wdata[3:0];
    else if (stage_wr && i_reg_addr == OFS_SELECT + 16'h0001)
      index_reg[7:0] <= i_reg_wdata;
  end

  // Control byte: start is self-clearing
  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      start_reg  <= 1'b0;
      action_reg <= VTA_ACT_NOP;
    end
    else if (ctrl_wr)
    begin
      start_reg  <= i_reg_wdata[POS_START];
      action_reg <= vta_action_t'(i_reg_wdata[POS_ACT_LO +: 2]);
    end
    else if (start_reg && state_next == VTA_ST_IDLE)
      start_reg <= 1'b0;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      VTA_ST_IDLE:
      begin
        if (start_reg)
        begin
          case (action_reg)
            VTA_ACT_WRITE, VTA_ACT_READ: state_next = VTA_ST_ACCESS;
            VTA_ACT_CLEAR:               state_next = VTA_ST_CLEAR;
            default:                     state_next = VTA_ST_IDLE;
          endcase
        end
      end
      VTA_ST_ACCESS:
        if (i_tbl_ack)
          state_next = VTA_ST_IDLE;
      VTA_ST_CLEAR:
        if (i_tbl_ack && clr_cnt_reg == IDX_W'(TABLE_DEPTH - 13'h0001))
          state_next = VTA_ST_IDLE;
      default: state_next = VTA_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      state_reg <= VTA_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Clear-all walks every entry
  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      clr_cnt_reg <= '0;
    else if (state_reg != VTA_ST_CLEAR)
      clr_cnt_reg <= '0;
    else if (i_tbl_ack)
      clr_cnt_reg <= clr_cnt_reg + IDX_W'(1);
  end

  // Table port
  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      o_tbl_req   <= 1'b0;
      o_tbl_we    <= 1'b0;
      o_tbl_addr  <= '0;
      o_tbl_wdata <= '0;
    end
    else if (state_next == VTA_ST_ACCESS && !(state_reg == VTA_ST_ACCESS && i_tbl_ack))
    begin
      o_tbl_req   <= 1'b1;
      o_tbl_we    <= (action_reg == VTA_ACT_WRITE);
      o_tbl_addr  <= index_reg;
      o_tbl_wdata <= staged_entry;
    end
    else if (state_next == VTA_ST_CLEAR)
    begin
      o_tbl_req   <= 1'b1;
      o_tbl_we    <= 1'b1;
      o_tbl_addr  <= (state_reg == VTA_ST_CLEAR && i_tbl_ack) ? clr_cnt_reg + IDX_W'(1) : clr_cnt_reg;
      o_tbl_wdata <= '0;
    end
    else
    begin
      o_tbl_req <= 1'b0;
      o_tbl_we  <= 1'b0;
    end
  end

  assign o_busy = start_reg;

  // Register read mux
  always_comb
  begin
    case (i_reg_addr)
      OFS_WORD0:              rd_byte = word0[31:24];
      OFS_WORD0 + 16'h0001:   rd_byte = word0[23:16];
      OFS_WORD0 + 16'h0002:   rd_byte = word0[15:8];
      OFS_WORD0 + 16'h0003:   rd_byte = word0[7:0];
      OFS_UNTAG + 16'h0003:   rd_byte = word_untag[7:0];
      OFS_FWD + 16'h0003:     rd_byte = word_fwd[7:0];
      OFS_SELECT:             rd_byte = word_sel[15:8];
      OFS_SELECT + 16'h0001:  rd_byte = word_sel[7:0];
      OFS_CTRL:               rd_byte = {start_reg, 5'h00, action_reg};
      default:                rd_byte = RST_BYTE;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      o_reg_rdata <= RST_BYTE;
    else if (i_reg_rd)
      o_reg_rdata <= rd_byte;
  end

  // Lookup decode of an entry from the table
  assign lkp_forward_option_bit = i_lkp_entry[ENT_FORWARD_OPTION_BIT];

  always_comb
  begin
    case (vta_fwd_src_t'(i_fwd_src))
      VTA_SRC_ALU:     fallback_map = i_alu_map;
      VTA_SRC_PORTMAP: fallback_map = i_vlan_map;
      VTA_SRC_BOTH:    fallback_map = i_alu_map & i_vlan_map;
      default:         fallback_map = i_unknown_map;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      o_lkp_hit     <= 1'b0;
      o_fwd_ports   <= '0;
      o_untag_ports <= '0;
      o_lkp_prio    <= 3'h0;
      o_lkp_mstp    <= 3'h0;
      o_lkp_filter_identifier <= 7'h00;
    end
    else if (i_lkp_valid && i_lkp_entry[ENT_VALID])
    begin
      o_lkp_hit     <= 1'b1;
      o_fwd_ports   <= lkp_forward_option_bit ? i_lkp_entry[ENT_FWD_LO +: PORTS_P] : fallback_map;
      o_untag_ports <= i_lkp_entry[ENT_UNTAG_LO +: PORTS_P];
      o_lkp_prio    <= i_lkp_entry[ENT_PRIO_LO +: 3];
      o_lkp_mstp    <= i_lkp_entry[ENT_MSTP_LO +: 3];
      o_lkp_filter_identifier <= i_lkp_entry[ENT_FILTER_IDENTIFIER_LO +: 7];
    end
    else
    begin
      o_lkp_hit     <= 1'b0;
      o_fwd_ports   <= '0;
      o_untag_ports <= '0;
    end
  end
endmodule : vta_regs

// ==== sim/vta_regs_sva.sv ====
// Purpose: Port-level assertions for the VLAN table staging registers
// Assumes: Software waits three edges after reset before the first access
// Notes:   Bound to every instance of vta_regs
`timescale 1ns/10ps
module vta_regs_sva
  import vta_pkg::*;
#(
  parameter int PORTS_P = 7
)(
  input wire logic                i_clock,       // Core clock
  input wire logic                i_nrst,        // Reset, active low
  input wire logic [15:0]         i_reg_addr,    // Register address
  input wire logic                i_reg_wr,      // Write strobe
  input wire logic [7:0]          i_reg_wdata,   // Write byte
  input wire logic                o_tbl_req,     // Table request
  input wire logic                o_tbl_we,      // Table write
  input wire logic [11:0]         o_tbl_addr,    // Table address
  input wire logic                i_tbl_ack,     // Table ack
  input wire logic                o_busy,        // Action running
  input wire logic                i_lkp_valid,   // Lookup strobe
  input wire logic [28:0]         i_lkp_entry,   // Lookup entry
  input wire logic                o_lkp_hit,     // Lookup hit
  input wire logic [PORTS_P-1:0]  o_fwd_ports,   // Forward ports
  input wire logic [PORTS_P-1:0]  o_untag_ports  // Untag ports
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Control write that launches an action from idle
  sequence s_go(logic [1:0] act);
    i_reg_wr && i_reg_addr == OFS_CTRL && i_reg_wdata == {1'b1, 5'b00000, act} && !o_busy;
  endsequence
  chk_req_holds: assert property (o_tbl_req && !i_tbl_ack |=> o_tbl_req && $stable(o_tbl_addr))
    else $error("table request dropped early");
  chk_req_in_busy: assert property (o_tbl_req |-> o_busy)
    else $error("table request outside action");
  chk_nop_done: assert property (s_go(2'b00) |=> o_busy ##1 !o_busy)
    else $error("no-op action timing wrong");
  chk_write_issue: assert property (s_go(2'b01) |=> ##1 o_tbl_req && o_tbl_we)
    else $error("write action did not write");
  chk_read_issue: assert property (s_go(2'b10) |=> ##1 o_tbl_req && !o_tbl_we)
    else $error("read action did not read");
  chk_clear_issue: assert property (s_go(2'b11) |=> ##1 o_tbl_req && o_tbl_we && o_tbl_addr == 12'h000)
    else $error("clear action did not start at zero");
  chk_hit_valid: assert property (i_lkp_valid |=> o_lkp_hit == $past(i_lkp_entry[28]))
    else $error("lookup hit wrong");
  chk_fwd_option: assert property (i_lkp_valid && i_lkp_entry[28] && i_lkp_entry[27] |=>
    o_fwd_ports == $past(i_lkp_entry[6:0]))
    else $error("forward map not applied");
  chk_untag_map: assert property (i_lkp_valid && i_lkp_entry[28] |=> o_untag_ports == $past(i_lkp_entry[13:7]))
    else $error("untag map wrong");
  chk_miss_zero: assert property (i_lkp_valid && !i_lkp_entry[28] |=> o_fwd_ports == '0 && o_untag_ports == '0)
    else $error("invalid entry forwarded");
endmodule : vta_regs_sva

bind vta_regs vta_regs_sva #(.PORTS_P(PORTS_P)) u_vta_regs_sva (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_tbl_req(o_tbl_req),
  .o_tbl_we(o_tbl_we), .o_tbl_addr(o_tbl_addr), .i_tbl_ack(i_tbl_ack), .o_busy(o_busy),
  .i_lkp_valid(i_lkp_valid), .i_lkp_entry(i_lkp_entry), .o_lkp_hit(o_lkp_hit),
  .o_fwd_ports(o_fwd_ports), .o_untag_ports(o_untag_ports));

// ==== sim/vta_regs_tb.sv ====
// Purpose: Self-checking bench for the VLAN table staging registers
// Assumes: Bench plays the table memory, acking one cycle after a request
// Notes:   Clear action walks all 4096 entries
`timescale 1ns/10ps
module vta_regs_tb;
  import vta_pkg::*;
  logic        i_clock, i_nrst, i_reg_wr, i_reg_rd, i_tbl_ack, i_lkp_valid, o_tbl_req, o_tbl_we, o_busy, o_lkp_hit;
  logic [15:0] i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata;
  logic [11:0] o_tbl_addr;
  logic [28:0] o_tbl_wdata, i_tbl_rdata, i_lkp_entry;
  logic [1:0]  i_fwd_src;
  logic [6:0]  i_alu_map, i_vlan_map, i_unknown_map, o_fwd_ports, o_untag_ports, o_lkp_filter_identifier;
  logic [2:0]  o_lkp_prio, o_lkp_mstp;
  logic [28:0] mem [4096];
  int          miscompares, num_checks;
  localparam logic [15:0] WA [9] = '{16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0404, 16'h0407, 16'h040B,
                                     16'h040C, 16'h040D};
  localparam logic [7:0]  WD [9] = '{8'hFD, 8'hFF, 8'hBF, 8'hD5, 8'hFF, 8'hAA, 8'h95, 8'hFA, 8'hBC};
  localparam logic [7:0]  RB [9] = '{8'h8D, 8'h00, 8'h30, 8'h55, 8'h00, 8'h2A, 8'h15, 8'h0A, 8'hBC};
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

  vta_regs u_vta_regs (.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_tbl_req(o_tbl_req),
    .o_tbl_we(o_tbl_we), .o_tbl_addr(o_tbl_addr), .o_tbl_wdata(o_tbl_wdata), .i_tbl_rdata(i_tbl_rdata),
    .i_tbl_ack(i_tbl_ack), .o_busy(o_busy), .i_lkp_valid(i_lkp_valid), .i_lkp_entry(i_lkp_entry),
    .i_fwd_src(i_fwd_src), .i_alu_map(i_alu_map), .i_vlan_map(i_vlan_map), .i_unknown_map(i_unknown_map),
    .o_lkp_hit(o_lkp_hit), .o_fwd_ports(o_fwd_ports), .o_untag_ports(o_untag_ports),
    .o_lkp_prio(o_lkp_prio), .o_lkp_mstp(o_lkp_mstp), .o_lkp_filter_identifier(o_lkp_filter_identifier));

  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // Table memory; read data scrambled outside the ack cycle
  always @(posedge i_clock)
  begin
    i_tbl_ack <= o_tbl_req && !i_tbl_ack;
    if (o_tbl_req && !i_tbl_ack && o_tbl_we) mem[o_tbl_addr] <= o_tbl_wdata;
    i_tbl_rdata <= (o_tbl_req && !i_tbl_ack) ? mem[o_tbl_addr] : ~i_tbl_rdata;
  end

  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd   <= 1'b0;
    @(posedge i_clock);
    #1 `CHK("register byte", e, o_reg_rdata)
  endtask : rd

  task automatic idle;
    int n;
    n = 0;
    #1;
    while (o_busy !== 1'b0 && n < 9000)
    begin
      @(posedge i_clock);
      #1 n++;
    end
    `CHK("busy", 1'b0, o_busy)
  endtask : idle

  task automatic lk(input logic [28:0] e, input logic [1:0] s);
    logic [6:0] f;
    @(posedge i_clock);
    i_lkp_entry <= e;
    i_fwd_src   <= s;
    i_lkp_valid <= 1'b1;
    @(posedge i_clock);
    i_lkp_valid <= 1'b0;
    f = e[27] ? e[6:0] : s == 2'b00 ? i_alu_map : s == 2'b01 ? i_vlan_map : s == 2'b10 ? i_alu_map & i_vlan_map
      : i_unknown_map;
    #1 `CHK("hit", e[28], o_lkp_hit)
    `CHK("forward ports", e[28] ? f : 7'h00, o_fwd_ports)
    `CHK("untag ports", e[28] ? e[13:7] : 7'h00, o_untag_ports)
    if (e[28])
      `CHK("prio mstp filter id", {e[26:21], e[20:14]}, {o_lkp_prio, o_lkp_mstp, o_lkp_filter_identifier})
  endtask : lk

  initial
  begin
    {i_nrst, i_reg_wr, i_reg_rd, i_lkp_valid, i_tbl_ack, i_fwd_src} = '0;
    {i_reg_addr, i_reg_wdata, i_tbl_rdata, i_lkp_entry} = '0;
    {i_alu_map, i_vlan_map, i_unknown_map} = {7'h0F, 7'h3C, 7'h41};
    miscompares = 0;
    num_checks  = 0;
    for (int i = 0; i < 4096; i++) mem[i] = 29'h0AAAAAAA;
    mem[12'h123] = {1'b0, 1'b1, 3'd2, 3'd6, 7'h11, 7'h44, 7'h7F};
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (int a = 16'h0400; a < 16'h0411; a++) rd(16'(a), 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) wr(WA[i], WD[i]);
    for (int i = 0; i < 9; i++) rd(WA[i], RB[i]);
    $display("test staging fields done");
    wr(16'h040E, 8'h81);
    wr(16'h0403, 8'h00);
    idle();
    `CHK("written entry", {1'b1, 1'b1, 3'd5, 3'd3, 7'h55, 7'h2A, 7'h15}, mem[12'hABC])
    rd(16'h0403, 8'h55);
    rd(16'h040E, 8'h01);
    $display("test write action done");
    wr(16'h040C, 8'h01);
    wr(16'h040D, 8'h23);
    wr(16'h040E, 8'h82);
    idle();
    rd(16'h0400, 8'h0A);
    rd(16'h0402, 8'h60);
    rd(16'h0403, 8'h11);
    rd(16'h0407, 8'h44);
    rd(16'h040B, 8'h7F);
    $display("test read action done");
    wr(16'h040E, 8'h80);
    idle();
    rd(16'h040E, 8'h00);
    `CHK("entry after no-op", {1'b0, 1'b1, 3'd2, 3'd6, 7'h11, 7'h44, 7'h7F}, mem[12'h123])
    wr(16'h040E, 8'h83);
    idle();
    `CHK("cleared entries", 87'h0, {mem[12'h000], mem[12'h123], mem[12'hFFF]})
    $display("test no-op and clear done");
    lk({1'b1, 1'b1, 3'd5, 3'd3, 7'h55, 7'h2A, 7'h15}, 2'b00);
    for (int s = 0; s < 4; s++) lk({1'b1, 1'b0, 3'd2, 3'd4, 7'h33, 7'h51, 7'h7E}, 2'(s));
    lk({1'b0, 1'b1, 3'd7, 3'd7, 7'h7F, 7'h7F, 7'h7F}, 2'b01);
    $display("test lookup done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    summarize();
  end
endmodule : vta_regs_tb
